// [bench/spi_eeprom_command_protect_test.sv]
// Purpose: host to device run of the eeprom pair driven over APB
// Assumes: write cycle shortened to 2000 clk
// Notes: array starts unknown, so only written bytes are read back
`include "eeprom_map.svh"
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_command_protect_test;
  localparam int Wc = 2000;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, busy;
  logic [32:0] expQ[$], mskQ[$], got, ex;
  int nErrors = 0, checkCount = 0, cycles = 0;

  spi_link_if link ();
  spi_eeprom_dev #(.WriteCycles(Wc)) i_spi_eeprom_dev (.clk(clk), .nrst(nrst), .link(link), .busy(busy));
  spi_eeprom_host i_spi_eeprom_host (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  spi_eeprom_properties #(.WriteCycles(Wc)) i_spi_eeprom_properties (.clk(clk), .nrst(nrst), .csN(link.csN),
    .sck(link.sck), .si(link.si), .soDev(link.soDev), .soOe(link.soOe), .busy(busy));

  initial forever #50 clk = ~clk;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic finalReport();
    if (nErrors == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // each finished read takes the oldest note; polls find the queue empty
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      got = {pslverr, prdata} & mskQ.pop_front();
      ex = expQ.pop_front();
      checkCount++;
      if (got !== ex) begin
        nErrors++;
        $display("FAIL at %0t got %h exp %h", $time, got, ex);
      end
    end
  end
  // hang guard, about three times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      nErrors++;
      finalReport();
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic checkRd(input logic [7:0] ad, input logic [32:0] e, input logic [32:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    apb(1'b0, ad, 32'h0);
  endtask
  // one byte on the link, then wait for the engine to go idle
  task automatic xfer(input logic [7:0] b, input logic last);
    apb(1'b1, `APB_DATA_OFS, {23'h0, last, b});
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, `APB_STATUS_OFS, 32'h0);
  endtask
  // random value in the ignored opcode bit
  function automatic logic [7:0] opJitter();
    return 8'($urandom() & 32'h8);
  endfunction
  task automatic op1(input logic [7:0] o);
    xfer(o | opJitter(), 1'b1);
  endtask
  task automatic hdr(input logic [7:0] o, input logic [23:0] a);
    xfer(o | opJitter(), 1'b0);
    for (int i = 2; i >= 0; i--) xfer(a[i*8 +: 8], 1'b0);
  endtask
  task automatic rdChk(input logic [7:0] e, input logic last);
    xfer(8'hff, last);
    checkRd(`APB_DATA_OFS, {25'h0, e}, 33'h1_0000_00ff);
  endtask
  task automatic stat(input logic [7:0] e);
    xfer(8'h05 | opJitter(), 1'b0);
    rdChk(e, 1'b1);
  endtask
  task automatic waitIdle();
    while (busy !== 1'b0) @(posedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v, w, u, y;
    void'($urandom(77));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    {v, w, u, y} = $urandom();
    checkRd(`APB_CONTROL_OFS, 33'h1, 33'h1_0000_0001);
    checkRd(8'h0c, 33'h1_0000_0000, 33'h1_ffff_ffff);
    stat(8'h00);
    op1(8'h06);
    stat(8'h02);
    op1(8'h04);
    stat(8'h00);
    // write without the latch must leave the device idle
    hdr(8'h02, 24'h000100);
    xfer(v, 1'b1);
    stat(8'h00);
    // page write that wraps in the low eight address bits
    op1(8'h06);
    hdr(8'h02, 24'hfe00fe);
    xfer(v, 1'b0);
    xfer(w, 1'b0);
    xfer(u, 1'b1);
    stat(8'hff);
    waitIdle();
    stat(8'h00);
    op1(8'h06);
    hdr(8'h02, 24'h01ffff);
    xfer(y, 1'b1);
    waitIdle();
    // quarter protection, then a refused write into it
    op1(8'h06);
    xfer(8'h01 | opJitter(), 1'b0);
    xfer(8'h04, 1'b1);
    stat(8'hff);
    waitIdle();
    stat(8'h04);
    op1(8'h06);
    hdr(8'h02, 24'h01ffff);
    xfer(~y, 1'b1);
    stat(8'h06);
    hdr(8'h03, 24'h01ffff);
    checkRd(`APB_STATUS_OFS, 33'h2, 33'h1_0000_0003);
    rdChk(y, 1'b0);
    rdChk(u, 1'b1);
    hdr(8'h03, 24'h0000fe);
    rdChk(v, 1'b0);
    rdChk(w, 1'b1);
    // pin protection blocks status writes while the pin is low
    xfer(8'h01, 1'b0);
    xfer(8'h84, 1'b1);
    waitIdle();
    stat(8'h84);
    apb(1'b1, `APB_CONTROL_OFS, 32'h0);
    op1(8'h06);
    xfer(8'h01, 1'b0);
    xfer(8'h00, 1'b1);
    op1(8'h04);
    stat(8'h84);
    apb(1'b1, `APB_CONTROL_OFS, 32'h1);
    op1(8'h06);
    xfer(8'h01, 1'b0);
    xfer(8'h00, 1'b1);
    waitIdle();
    stat(8'h00);
    // bad opcodes leave the output released, read back as the pull-up
    foreach (v[i]) if (i < 3) begin
      xfer(i == 0 ? 8'h00 : (i == 1 ? 8'h07 : 8'h52), 1'b0);
      rdChk(8'hff, 1'b1);
    end
    finalReport();
  end
endmodule // spi_eeprom_command_protect_test
`default_nettype wire

// [bench/spi_eeprom_properties.sv]
// Purpose: link-level checks on the eeprom host and device pair
// Assumes: host serial clock half period of 8 clk
// Notes: watches interface nets and the device busy flag only
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_properties #(
  parameter int WriteCycles = 2000
) (
  input wire logic clk, // system clock
  input wire logic nrst, // reset, low
  input wire logic csN, // chip select, low
  input wire logic sck, // serial clock
  input wire logic si, // data to device
  input wire logic soDev, // device data out
  input wire logic soOe, // device drives out
  input wire logic busy // write cycle running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // counts busy cycles so the cycle length is checked exactly, not loosely
  int busyCnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      busyCnt <= 0;
    else if (!busy)
      busyCnt <= 0;
    else
      busyCnt <= busyCnt + 1;
  end
  sequence sHighPhase;
    sck [*8] ##1 !sck;
  endsequence
  sequence sCycleStart;
    csN ##1 busy [*8];
  endsequence

  a_clock_in_frame: assert property ($rose(sck) |-> !csN)
    else $error("serial clock rose outside a frame");
  a_clock_idle_low: assert property (csN |-> !sck)
    else $error("serial clock high while deselected");
  a_high_phase: assert property ($rose(sck) |-> sHighPhase)
    else $error("serial clock high phase not 8 cycles");
  a_data_steady: assert property (sck |-> $stable(si))
    else $error("data to device moved while clock high");
  a_end_low_phase: assert property ($rose(csN) |-> !$past(sck) && !$past(sck, 8))
    else $error("select rose outside the low phase");
  a_idle_released: assert property (csN [*4] |-> !soOe)
    else $error("device drives output while deselected");
  a_cycle_on_rise: assert property ($rose(busy) |-> sCycleStart)
    else $error("write cycle began inside a frame");
  a_cycle_length: assert property ($fell(busy) |-> busyCnt == WriteCycles)
    else $error("write cycle length wrong");
  // output is only meaningful once the first falling edge has shifted a bit out
  a_busy_all_ones: assert property (busy && $past(busy, 4) && soOe && $past(soOe, 8) |-> soDev)
    else $error("status bit low during write cycle");
endmodule // spi_eeprom_properties
`default_nettype wire

// [core/eeprom_map.svh]
// Purpose: constants shared by the serial eeprom device end and its host end
// Assumes: 10 MHz system clock on both ends, serial mode 0
// Notes: opcode values give only the low three bits; bit 3 is never compared
// Notes on behaviour
// [R01] frame opens on chip select fall, MSB first
// [R02] decode set, clear latch and status read
// [R03] decode status write, array read, array write
// [R04] latch clear at reset, set before programming
// [R05] clear-latch stops programming whatever the pin
// [R06] status bit0 busy, bit1 latch
// [R07] bits 4-6 zero idle, all ones busy
// [R08] two protect bits choose protected range
// [R09] protect bits written via latch and timed cycle
// [R10] pin low plus enable blocks status writes
// [R11] array and status writes need latch, no protection
// [R12] protected enable bit stays set while pin low
// [R13] read: opcode, three address bytes, data out
// [R14] read address increments and wraps to zero
// [R15] busy device accepts only status read
// [R16] programming starts when chip select rises
// [R17] host raises select in low phase after D0
// [R18] page write bumps low eight bits only
// [R19] latch cleared when write cycle ends
// [R20] write without latch ignored until new frame
// [R21] address bits above 16 ignored
// [R22] bad opcode: no input, output released
// [R23] pin low during status frame aborts it
// [R24] busy timer runs from select rise
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

`define OP_HI_NIBBLE 4'h0
`define OP_SET_LATCH 3'h6
`define OP_CLEAR_LATCH 3'h4
`define OP_READ_STATUS 3'h5
`define OP_WRITE_STATUS 3'h1
`define OP_READ_ARRAY 3'h3
`define OP_WRITE_ARRAY 3'h2

`define ST_BUSY_BIT 0
`define ST_LATCH_BIT 1
`define ST_BP_LO_BIT 2
`define ST_BP_HI_BIT 3
`define ST_PIN_EN_BIT 7
`define ST_ALL_BUSY 8'hff
`define ST_IDLE_ZERO 8'h00

`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2
`define BP_ALL 2'h3
`define PROT_QUARTER_BASE 17'h18000
`define PROT_HALF_BASE 17'h10000

`define ADDR_W 17
`define MEM_DEPTH 131072
`define PAGE_BYTES 256
`define ADDR_LAST_BYTE 2'h2

`define WRITE_CYCLE_TIME_MS 5
`define CLK_PERIOD_NS 100
`define SCK_HALF_NS 800
`define SCK_HALF_CYCLES ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_RESET 4'h9

`define APB_DATA_OFS 8'h00
`define APB_STATUS_OFS 8'h04
`define APB_CONTROL_OFS 8'h08
`define DATA_LAST_BIT 8

`endif

// [core/eeprom_pkg.sv]
// Purpose: state types of both serial eeprom ends
// Assumes: nothing
// Notes: constants live in eeprom_map.svh
package eeprom_pkg;
  typedef enum logic [2:0] {DS_IDLE, DS_OPCODE, DS_ADDR, DS_RDATA, DS_WDATA, DS_STATR, DS_STATW, DS_IGNORE} dev_state_type;
  typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP} host_state_type;
endpackage

// [core/spi_eeprom_dev.sv]
// Purpose: instruction decoder, protection and array of a 1-Mbit serial eeprom
// Assumes: link pins are asynchronous; serial clock half period of at least 4 clk
// Notes: page bytes are buffered and copied into the array during the busy time
`include "eeprom_map.svh"
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_dev
  import eeprom_pkg::*;
#(
  parameter int WriteCycles = `WRITE_CYCLE_TIME_MS * 1000000 / `CLK_PERIOD_NS
) (
  input wire logic clk, // system clock
  input wire logic nrst, // asynchronous reset, low
  spi_link_if.dev link, // serial link
  output logic busy // internal write cycle running
);
  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  logic csPrev_reg;
  logic sckPrev_reg;
  logic csS, sckS, siS, wpS;
  logic frameStart, frameEnd, sckRise, sckFall;

  // two stages for every pin, first stage read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA_reg <= `SYNC_RESET;
      syncB_reg <= `SYNC_RESET;
      csPrev_reg <= 1'b1;
      sckPrev_reg <= 1'b0;
    end else begin
      syncA_reg <= {link.csN, link.sck, link.si, link.wpN};
      syncB_reg <= syncA_reg;
      csPrev_reg <= syncB_reg[3];
      sckPrev_reg <= syncB_reg[2];
    end
  end

  assign csS = syncB_reg[3];
  assign sckS = syncB_reg[2];
  assign siS = syncB_reg[1];
  assign wpS = syncB_reg[0];
  assign frameStart = csPrev_reg && !csS; // R01
  assign frameEnd = !csPrev_reg && csS;
  assign sckRise = !sckPrev_reg && sckS && !csS;
  assign sckFall = sckPrev_reg && !sckS && !csS;

  // ----------------------------------------------------------------
  // bit shifting and decode
  // ----------------------------------------------------------------
  dev_state_type state_reg, opNext;
  logic [2:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] rxByte;
  logic byteDone, opAccept, busy_reg, wel_reg, hwProt, protHit, loadNext_reg;
  logic isRead_reg, gotByte_reg, hwAbort_reg, wrArray_reg, startCycle, cycleDone;
  logic [1:0] addrCnt_reg;
  logic [1:0] bp_reg;
  logic [1:0] stagedBp_reg;
  logic pinEn_reg, stagedPin_reg;
  logic [`ADDR_W-1:0] addr_reg;
  logic [7:0] statusByte;

  assign rxByte = {shift_reg[6:0], siS}; // R01
  assign byteDone = sckRise && bitCnt_reg == 3'h7;
  assign opAccept = byteDone && state_reg == DS_OPCODE && rxByte[7:4] == `OP_HI_NIBBLE && !busy_reg;

  // counts bits of the frame; shifting stops once the opcode is rejected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (frameStart) begin
      bitCnt_reg <= 3'h0;
    end else if (sckRise) begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
      if (state_reg != DS_IGNORE) begin // R22
        shift_reg <= rxByte;
      end
    end
  end

  // opcode decode, bit 3 never looked at
  always_comb begin
    opNext = DS_IGNORE;
    if (rxByte[7:4] == `OP_HI_NIBBLE && (!busy_reg || rxByte[2:0] == `OP_READ_STATUS)) begin // R15
      unique case (rxByte[2:0])
        `OP_READ_STATUS: opNext = DS_STATR; // R02
        `OP_WRITE_STATUS: opNext = wel_reg ? DS_STATW : DS_IGNORE; // R03 R20
        `OP_READ_ARRAY: opNext = DS_ADDR; // R03
        `OP_WRITE_ARRAY: opNext = wel_reg ? DS_ADDR : DS_IGNORE; // R03 R20
        default: opNext = DS_IGNORE; // R02 R22
      endcase
    end
  end

  // frame sequencer; a rejected frame waits for chip select to rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= DS_IDLE;
    end else if (frameStart) begin
      state_reg <= DS_OPCODE;
    end else if (csS) begin
      state_reg <= DS_IDLE;
    end else if (byteDone) begin
      unique case (state_reg)
        DS_OPCODE: state_reg <= opNext;
        DS_ADDR: if (addrCnt_reg == `ADDR_LAST_BYTE) state_reg <= isRead_reg ? DS_RDATA : DS_WDATA; // R13
        DS_IDLE, DS_RDATA, DS_WDATA, DS_STATR, DS_STATW, DS_IGNORE: state_reg <= state_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address and page buffer
  // ----------------------------------------------------------------
  logic [7:0] pageBuf [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] pageValid_reg;
  logic [7:0] mem [`MEM_DEPTH];
  logic [8:0] commitIdx_reg;

  // address capture and stepping
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addrCnt_reg <= 2'h0;
      addr_reg <= '0;
      isRead_reg <= 1'b0;
    end else begin
      if (opAccept) begin
        isRead_reg <= rxByte[2:0] == `OP_READ_ARRAY;
        addrCnt_reg <= 2'h0;
      end else if (byteDone && state_reg == DS_ADDR) begin
        addr_reg <= {addr_reg[8:0], rxByte}; // R21
        addrCnt_reg <= addrCnt_reg + 2'h1;
      end else if (byteDone && state_reg == DS_WDATA) begin
        addr_reg[7:0] <= addr_reg[7:0] + 8'h01; // R18
      end else if (loadNext_reg && state_reg == DS_RDATA) begin
        addr_reg <= addr_reg + `ADDR_W'(1); // R14
      end
    end
  end

  // bytes collect here so nothing is programmed before select rises
  always_ff @(posedge clk) begin
    if (byteDone && state_reg == DS_WDATA) begin
      pageBuf[addr_reg[7:0]] <= rxByte; // R18
    end
  end

  // which page slots hold a received byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pageValid_reg <= '0;
    end else if (byteDone && state_reg == DS_ADDR && addrCnt_reg == `ADDR_LAST_BYTE && !isRead_reg) begin
      pageValid_reg <= '0;
    end else if (byteDone && state_reg == DS_WDATA) begin
      pageValid_reg[addr_reg[7:0]] <= 1'b1;
    end
  end

  // copy one page slot per clock; needs WriteCycles of at least 256
  always_ff @(posedge clk) begin
    if (busy_reg && wrArray_reg && !commitIdx_reg[8] && pageValid_reg[commitIdx_reg[7:0]]) begin
      mem[{addr_reg[16:8], commitIdx_reg[7:0]}] <= pageBuf[commitIdx_reg[7:0]]; // R16
    end
  end

  // ----------------------------------------------------------------
  // protection and write cycle
  // ----------------------------------------------------------------
  logic [31:0] busyCnt_reg;

  assign hwProt = !wpS && pinEn_reg; // R10

  // range check on the held page address
  always_comb begin
    unique case (bp_reg)
      `BP_NONE: protHit = 1'b0; // R08
      `BP_QUARTER: protHit = addr_reg >= `PROT_QUARTER_BASE; // R08
      `BP_HALF: protHit = addr_reg >= `PROT_HALF_BASE; // R08
      `BP_ALL: protHit = 1'b1; // R08
    endcase
  end

  // only a whole-byte frame ending at a byte edge starts programming
  assign startCycle = frameEnd && bitCnt_reg == 3'h0 && gotByte_reg && wel_reg &&
    ((state_reg == DS_WDATA && !protHit) || (state_reg == DS_STATW && !hwProt && !hwAbort_reg)); // R11 R16 R10 R12
  assign cycleDone = busy_reg && busyCnt_reg == 32'(WriteCycles - 1);

  // frame bookkeeping, the pin abort looks only at the open frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gotByte_reg <= 1'b0;
      hwAbort_reg <= 1'b0;
      stagedBp_reg <= 2'h0;
      stagedPin_reg <= 1'b0;
    end else if (frameStart) begin
      gotByte_reg <= 1'b0;
      hwAbort_reg <= 1'b0;
    end else begin
      if (byteDone && (state_reg == DS_WDATA || state_reg == DS_STATW)) gotByte_reg <= 1'b1;
      if (state_reg == DS_STATW && hwProt) hwAbort_reg <= 1'b1; // R23
      if (byteDone && state_reg == DS_STATW) begin
        stagedBp_reg <= {rxByte[`ST_BP_HI_BIT], rxByte[`ST_BP_LO_BIT]};
        stagedPin_reg <= rxByte[`ST_PIN_EN_BIT];
      end
    end
  end

  // timed cycle; the pin is no longer watched once it runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      busyCnt_reg <= 32'h0;
      commitIdx_reg <= 9'h000;
      wrArray_reg <= 1'b0;
    end else if (startCycle) begin
      busy_reg <= 1'b1; // R24
      busyCnt_reg <= 32'h0;
      commitIdx_reg <= 9'h000;
      wrArray_reg <= state_reg == DS_WDATA;
    end else if (busy_reg) begin
      busyCnt_reg <= busyCnt_reg + 32'h1; // R24 R23
      if (!commitIdx_reg[8]) commitIdx_reg <= commitIdx_reg + 9'h001;
      if (cycleDone) busy_reg <= 1'b0;
    end
  end

  // nonvolatile protect bits land at the end of the cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bp_reg <= 2'h0;
      pinEn_reg <= 1'b0;
    end else if (cycleDone && !wrArray_reg) begin
      bp_reg <= stagedBp_reg; // R09
      pinEn_reg <= stagedPin_reg; // R09
    end
  end

  // write-enable latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wel_reg <= 1'b0; // R04
    end else if (opAccept && rxByte[2:0] == `OP_SET_LATCH) begin
      wel_reg <= 1'b1; // R02
    end else if (opAccept && rxByte[2:0] == `OP_CLEAR_LATCH) begin
      wel_reg <= 1'b0; // R05
    end else if (cycleDone) begin
      wel_reg <= 1'b0; // R19
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic [7:0] outShift_reg;
  logic soDev_reg;
  logic soOe_reg;

  // status as the host sees it
  always_comb begin
    statusByte = `ST_IDLE_ZERO; // R07
    statusByte[`ST_LATCH_BIT] = wel_reg; // R06
    statusByte[`ST_BP_LO_BIT] = bp_reg[0];
    statusByte[`ST_BP_HI_BIT] = bp_reg[1];
    statusByte[`ST_PIN_EN_BIT] = pinEn_reg;
    if (busy_reg) statusByte = `ST_ALL_BUSY; // R06 R07
  end

  // a byte is fetched right after the rising edge that ends the previous one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loadNext_reg <= 1'b0;
    end else begin
      // status read is taken while busy too, so its byte must load then as well
      loadNext_reg <= (byteDone && state_reg == DS_OPCODE && opNext == DS_STATR) ||
        (byteDone && state_reg == DS_ADDR && addrCnt_reg == `ADDR_LAST_BYTE && isRead_reg) ||
        (byteDone && (state_reg == DS_RDATA || state_reg == DS_STATR)); // R13 R14 R15
    end
  end

  // data changes on the falling edge so the host samples it on the rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      outShift_reg <= 8'h00;
      soDev_reg <= 1'b0;
      soOe_reg <= 1'b0;
    end else begin
      soOe_reg <= !csS && (state_reg == DS_RDATA || state_reg == DS_STATR); // R22
      if (loadNext_reg) begin
        outShift_reg <= (state_reg == DS_STATR) ? statusByte : mem[addr_reg]; // R13
      end else if (sckFall && soOe_reg) begin
        soDev_reg <= outShift_reg[7]; // R13
        outShift_reg <= {outShift_reg[6:0], 1'b0};
      end
    end
  end

  assign link.soDev = soDev_reg;
  assign link.soOe = soOe_reg;
  assign busy = busy_reg;
endmodule // spi_eeprom_dev
`default_nettype wire

// [core/spi_eeprom_host.sv]
// Purpose: serial master for the eeprom, steered over APB byte by byte
// Assumes: serial clock is divided from clk; output line read through two flops
// Notes: software ends a frame by flagging its last byte
`include "eeprom_map.svh"
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_host
  import eeprom_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic nrst, // asynchronous reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  spi_link_if.host link // serial link
);
  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  host_state_type hstate_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, wpN_reg, csN_reg, sck_reg, mosi_reg;
  logic [7:0] rxData_reg;
  logic setupPhase, accessPhase, startXfer;
  logic [31:0] readMux;
  logic mapped;

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable && pready_reg;
  assign startXfer = accessPhase && pwrite && paddr == `APB_DATA_OFS && hstate_reg == HS_IDLE;

  // register read mux
  always_comb begin
    readMux = 32'h0;
    mapped = 1'b1;
    unique case (paddr)
      `APB_DATA_OFS: readMux[7:0] = rxData_reg;
      `APB_STATUS_OFS: readMux[1:0] = {!csN_reg, hstate_reg != HS_IDLE};
      `APB_CONTROL_OFS: readMux[0] = wpN_reg;
      default: mapped = 1'b0;
    endcase
  end

  // no wait state: answer prepared in the setup cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setupPhase;
      if (setupPhase) begin
        prdata_reg <= pwrite ? 32'h0 : readMux;
        pslverr_reg <= !mapped;
      end
    end
  end

  // write-protect pin level, released high after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wpN_reg <= 1'b1;
    end else if (accessPhase && pwrite && paddr == `APB_CONTROL_OFS) begin
      wpN_reg <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  logic [7:0] txShift_reg;
  logic [7:0] rxShift_reg;
  logic lastFlag_reg;
  logic [2:0] bitIdx_reg;
  logic [3:0] halfCnt_reg;
  logic [1:0] soSync_reg;
  logic halfDone;

  assign halfDone = halfCnt_reg == 4'(`SCK_HALF_CYCLES - 1);

  // output line passes two flops before it is sampled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soSync_reg <= 2'h3;
    end else begin
      soSync_reg <= {soSync_reg[0], link.soLine};
    end
  end

  // clock divider and frame sequencing, mode 0
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hstate_reg <= HS_IDLE;
      halfCnt_reg <= 4'h0;
      bitIdx_reg <= 3'h0;
      txShift_reg <= 8'h00;
      lastFlag_reg <= 1'b0;
      csN_reg <= 1'b1;
      sck_reg <= 1'b0;
      mosi_reg <= 1'b0;
    end else begin
      halfCnt_reg <= halfDone ? 4'h0 : halfCnt_reg + 4'h1;
      unique case (hstate_reg)
        HS_IDLE: begin
          halfCnt_reg <= 4'h0;
          if (startXfer) begin
            csN_reg <= 1'b0; // R01
            txShift_reg <= pwdata[7:0];
            mosi_reg <= pwdata[7]; // R01
            lastFlag_reg <= pwdata[`DATA_LAST_BIT];
            hstate_reg <= HS_LOW;
          end
        end
        HS_LOW: if (halfDone) begin
          sck_reg <= 1'b1;
          hstate_reg <= HS_HIGH;
        end
        HS_HIGH: if (halfDone) begin
          sck_reg <= 1'b0;
          bitIdx_reg <= bitIdx_reg + 3'h1;
          txShift_reg <= {txShift_reg[6:0], 1'b0};
          mosi_reg <= txShift_reg[6];
          if (bitIdx_reg == 3'h7) hstate_reg <= lastFlag_reg ? HS_TAIL : HS_IDLE;
          else hstate_reg <= HS_LOW;
        end
        HS_TAIL: if (halfDone) begin
          csN_reg <= 1'b1; // R17
          hstate_reg <= HS_GAP;
        end
        HS_GAP: if (halfDone) hstate_reg <= HS_IDLE;
      endcase
    end
  end

  // sample on the rising edge, hand the byte over after its eighth bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxShift_reg <= 8'h00;
      rxData_reg <= 8'h00;
    end else if (hstate_reg == HS_LOW && halfDone) begin
      rxShift_reg <= {rxShift_reg[6:0], soSync_reg[1]}; // R13
      if (bitIdx_reg == 3'h7) rxData_reg <= {rxShift_reg[6:0], soSync_reg[1]};
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign link.csN = csN_reg;
  assign link.sck = sck_reg;
  assign link.si = mosi_reg;
  assign link.wpN = wpN_reg;
endmodule // spi_eeprom_host
`default_nettype wire

// [core/spi_link_if.sv]
// Purpose: serial link between eeprom device end and host end
// Assumes: serial output line pulled high when released
// Notes: the only place the released output is resolved
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic csN;
  logic sck;
  logic si;
  logic wpN;
  logic soDev;
  logic soOe;
  logic soLine;

  // released line reads as the pull-up level
  assign soLine = soOe ? soDev : 1'b1;

  modport dev (input csN, input sck, input si, input wpN, output soDev, output soOe);
  modport host (output csN, output sck, output si, output wpN, input soLine);
endinterface
`default_nettype wire
